// ### verilog/fcio_master.sv
`timescale 1ns/10ps
// How it works
// - Up to 126 stations on one segment
// - Per-slave images at most 246 bytes
// - Stop state exchanges no data
// - Clear reads inputs, outputs held fail-safe
// - Operate reads and writes every slave cycle
// - Master state multicast at configured interval
// - Fallback on: slave fault forces clear
// - Fallback off: stay operating, user reacts
// - Parameterize, configure, then transfer data
// - Planned and actual configuration must match
// - Only assigned master writes outputs
// - Others get readable image only
// - Control commands to one, group, all
// - Sync holds outputs until next sync
// - Unsync resumes direct output updates
// - Freeze captures inputs until next freeze
// - Unfreeze resumes live inputs
// - Per-slave response timer trips on silence
// - Slave watchdog forces fail-safe outputs
// - Acyclic traffic never disturbs cyclic exchange
module fcio_master
   import fcio_pkg::*;
#(
   parameter int NSLV = 4, // Assigned slaves polled in turn
   parameter int STATUS_CYC = STATUS_INTERVAL_CYC // Status period
)
(
   input wire logic clk_sys_i, // System clock
   input wire logic sys_rst_i, // Async reset, active high
   fcio_link_if.master link, // Bus side
   input wire logic [ADDR_W-1:0] own_addr_i, // Master address
   input wire logic [NSLV*ADDR_W-1:0] slv_addr_i, // Slave addresses
   input wire fcio_cfg_t plan_cfg_i, // Planned slave config
   input wire fcio_mstate_t req_state_i, // Requested state
   input wire logic auto_clear_i, // Fallback option
   input wire logic [TMR_W-1:0] resp_limit_i, // Response interval
   input wire logic [NSLV*DATA_W-1:0] out_data_i, // Output values
   input wire logic [DATA_W-1:0] safe_out_i, // Fail-safe value
   input wire logic cmd_req_i, // Issue control command
   input wire fcio_cmd_t cmd_code_i, // Command code
   input wire logic [ADDR_W-1:0] cmd_dst_i, // Slave, group or all
   output fcio_mstate_t state_o, // Current state
   output logic [NSLV*DATA_W-1:0] in_data_o, // Latest inputs
   output logic [NSLV-1:0] slv_ready_o, // Slave in data phase
   output logic [NSLV-1:0] tmr_trip_o // Response timer tripped
);
   // Index into the slave list; a single slave still needs one bit
   localparam int IDX_W = $clog2(NSLV) > 0 ? $clog2(NSLV) : 1;
   // Status counter is sized to hold the full period
   localparam int ST_W = $clog2(STATUS_CYC + 1);

   typedef struct packed {
      fcio_mstate_t mstate;
      logic [IDX_W-1:0] idx;
      logic busy;
      // Per-slave phase, response timer, trip flag and input copy
      logic [NSLV-1:0][1:0] sphase;
      logic [NSLV-1:0][TMR_W-1:0] tmr;
      logic [NSLV-1:0] trip;
      logic [NSLV-1:0][DATA_W-1:0] inimg;
      logic [ST_W-1:0] st_cnt;
      // Frame being sent; it stands for one cycle only
      logic tx_valid;
      fcio_kind_t tx_kind;
      logic [ADDR_W-1:0] tx_dst;
      logic [1:0] tx_code;
      logic [DATA_W-1:0] tx_data;
      // A command waits here until the link is free
      logic pend_cmd;
      fcio_cmd_t cmd_code;
      logic [ADDR_W-1:0] cmd_dst;
      // Registered copies so every output leaves a flop
      logic [NSLV-1:0] rdy;
      logic [ADDR_W-1:0] tx_src;
      fcio_cfg_t tx_cfg;
   } st_t;
   st_t st_r, st_nxt;

   // Address of slave i from the packed list
   function automatic logic [ADDR_W-1:0] slv_addr(input int i);
      slv_addr = slv_addr_i[i*ADDR_W +: ADDR_W];
   endfunction

   // Poll engine: one frame out, wait for the reply, move on
   always_comb begin
      logic fault;
      st_nxt = st_r;
      st_nxt.tx_valid = 1'b0;
      fault = 1'b0;
      // Commands are latched so a busy link delays the latest one rather than losing it
      // A later request overwrites one not yet sent
      if (cmd_req_i) begin
         st_nxt.pend_cmd = 1'b1;
         st_nxt.cmd_code = cmd_code_i;
         st_nxt.cmd_dst = cmd_dst_i;
      end
      // Per-slave timers run only in data phase
      // A trip drops the slave back to parameterization
      for (int i = 0; i < NSLV; i++) begin
         if (st_r.sphase[i] == 2'(SP_DATA)) begin
            if (st_r.tmr[i] < resp_limit_i) begin
               st_nxt.tmr[i] = st_r.tmr[i] + 1'b1;
            end else begin
               st_nxt.trip[i] = 1'b1;
               st_nxt.sphase[i] = 2'(SP_WAIT_PRM);
               fault = 1'b1;
            end
         end
         // Replies are matched to a slave by their source address
         if (link.s_valid && link.s_src == slv_addr(i)) begin
            if (st_r.sphase[i] == 2'(SP_DATA) && link.s_ok) begin
               st_nxt.tmr[i] = TMR_W'(ZERO_CNT);
               st_nxt.trip[i] = 1'b0;
               st_nxt.inimg[i] = link.s_data;
            end else if (st_r.sphase[i] == 2'(SP_WAIT_PRM) && link.s_ok) begin
               st_nxt.sphase[i] = 2'(SP_WAIT_CFG);
            end else if (st_r.sphase[i] == 2'(SP_WAIT_CFG)) begin
               st_nxt.sphase[i] = link.s_ok ? 2'(SP_DATA)
                  : 2'(SP_WAIT_PRM);
               st_nxt.tmr[i] = TMR_W'(ZERO_CNT);
            end
         end
      end
      // Any reply ends the wait and moves to the next slave
      // A slave that never answers stalls polling; the link is trusted
      if (link.s_valid) begin
         st_nxt.busy = 1'b0;
         st_nxt.idx = (int'(st_r.idx) == NSLV - 1) ? '0
            : st_r.idx + 1'b1;
      end
      // State selection and fallback
      // Stop, clear and operate follow the request directly
      // Trade-off: the clear state is rebuilt every cycle, not latched
      st_nxt.mstate = req_state_i;
      // A fault, or a trip still standing, forces clear while operate
      // is asked for, so enabling fallback late still reacts
      if (req_state_i == MS_OPERATE && auto_clear_i &&
            (fault || |st_r.trip)) begin
         st_nxt.mstate = MS_CLEAR;
      end // Without fallback, operate holds and trips only report
      // The status period runs free and restarts at each status frame
      st_nxt.st_cnt = st_r.st_cnt + 1'b1;
      // Frame scheduling; status and commands outrank polling
      if (!st_r.busy && !st_r.tx_valid) begin
         if (int'(st_r.st_cnt) >= STATUS_CYC) begin
            st_nxt.st_cnt = '0;
            st_nxt.tx_valid = 1'b1;
            st_nxt.tx_kind = FK_STATUS;
            st_nxt.tx_dst = ADDR_ALL;
            st_nxt.tx_code = 2'(st_r.mstate);
         end else if (st_r.pend_cmd && !cmd_req_i) begin
            st_nxt.pend_cmd = 1'b0;
            st_nxt.tx_valid = 1'b1;
            st_nxt.tx_kind = FK_CONTROL;
            st_nxt.tx_dst = st_r.cmd_dst;
            st_nxt.tx_code = 2'(st_r.cmd_code);
         end else if (st_r.mstate != MS_STOP) begin
            st_nxt.tx_valid = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.tx_dst = slv_addr(int'(st_r.idx));
            // Phase decides the frame kind; code 3 never occurs
            unique case (fcio_sphase_t'(st_r.sphase[st_r.idx]))
               SP_WAIT_PRM: st_nxt.tx_kind = FK_PARAM;
               SP_WAIT_CFG: st_nxt.tx_kind = FK_CONFIG;
               SP_DATA: st_nxt.tx_kind = FK_DATA;
               default: st_nxt.tx_kind = FK_PARAM;
            endcase
            // Outside operate the fail-safe byte goes out instead
            // One byte each way per frame, well inside the image limit
            st_nxt.tx_data = (st_r.mstate == MS_OPERATE) ?
               out_data_i[int'(st_r.idx)*DATA_W +: DATA_W]
               : safe_out_i;
         end
      end
      // Ready flags and link identity are registered with the rest
      for (int i = 0; i < NSLV; i++) begin
         st_nxt.rdy[i] = st_nxt.sphase[i] == 2'(SP_DATA);
      end
      st_nxt.tx_src = own_addr_i;
      st_nxt.tx_cfg = plan_cfg_i;
   end

   // Whole state registered at once; reset leaves the master stopped
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Link outputs straight from state
   assign link.m_valid = st_r.tx_valid;
   assign link.m_kind = st_r.tx_kind;
   assign link.m_dst = st_r.tx_dst;
   assign link.m_src = st_r.tx_src;
   assign link.m_code = st_r.tx_code;
   assign link.m_cfg = st_r.tx_cfg;
   assign link.m_data = st_r.tx_data;
   assign state_o = st_r.mstate;
   assign in_data_o = st_r.inimg;
   assign tmr_trip_o = st_r.trip;
   // One ready flag per slave, each from its own flop
   generate
      for (genvar g = 0; g < NSLV; g++) begin : g_rdy
         assign slv_ready_o[g] = st_r.rdy[g];
      end
   endgenerate
endmodule

// ### verilog/fcio_pkg.sv
package fcio_pkg;
   // Bus population and per-slave image limits
   localparam int MAX_STATIONS = 126;
   localparam int ADDR_W = 7;
   localparam int MAX_IO_BYTES = 246;
   localparam int LEN_W = 8;
   localparam int DATA_W = 8;
   // Broadcast station address for multicast control commands
   localparam logic [ADDR_W-1:0] ADDR_ALL = 7'h7F;
   // Timing defaults in cycles at 250 MHz (4 ns)
   localparam int CLK_PERIOD_NS = 4;
   localparam int STATUS_INTERVAL_US = 10;
   localparam int STATUS_INTERVAL_CYC = STATUS_INTERVAL_US * 1000
      / CLK_PERIOD_NS;
   localparam int TMR_W = 24;
   localparam int ZERO_CNT = 0;

   // Frame kinds carried on the shared link
   typedef enum logic [2:0] {
      FK_PARAM,
      FK_CONFIG,
      FK_DATA,
      FK_STATUS,
      FK_CONTROL
   } fcio_kind_t;

   // Master operating states, also broadcast to slaves
   typedef enum logic [1:0] {
      MS_STOP,
      MS_CLEAR,
      MS_OPERATE
   } fcio_mstate_t;

   // Control command codes
   typedef enum logic [1:0] {
      CC_SYNC,
      CC_UNSYNC,
      CC_FREEZE,
      CC_UNFREEZE
   } fcio_cmd_t;

   // Slave phases
   typedef enum logic [1:0] {
      SP_WAIT_PRM,
      SP_WAIT_CFG,
      SP_DATA
   } fcio_sphase_t;

   // Configuration descriptor compared before data transfer
   typedef struct packed {
      logic [7:0] dev_type;
      logic [3:0] format;
      logic [LEN_W-1:0] in_len;
      logic [LEN_W-1:0] out_len;
   } fcio_cfg_t;
endpackage

// ### verilog/fcio_link_if.sv
`timescale 1ns/10ps
// Shared serial bus modelled as one-cycle frame strobes in each direction
interface fcio_link_if;
   import fcio_pkg::*;
   logic m_valid;
   fcio_kind_t m_kind;
   logic [ADDR_W-1:0] m_dst;
   logic [ADDR_W-1:0] m_src;
   logic [1:0] m_code;
   fcio_cfg_t m_cfg;
   logic [DATA_W-1:0] m_data;
   logic s_valid;
   logic [ADDR_W-1:0] s_src;
   logic s_ok;
   logic [DATA_W-1:0] s_data;
   logic [DATA_W-1:0] s_out_img;

   modport master (
      output m_valid, m_kind, m_dst, m_src, m_code, m_cfg, m_data,
      input s_valid, s_src, s_ok, s_data, s_out_img
   );
   modport slave (
      input m_valid, m_kind, m_dst, m_src, m_code, m_cfg, m_data,
      output s_valid, s_src, s_ok, s_data, s_out_img
   );
endinterface

// ### verilog/fcio_slave.sv
`timescale 1ns/10ps
// Slave end: phases, config check, sync/freeze, watchdog, access guard
module fcio_slave
   import fcio_pkg::*;
(
   input wire logic clk_sys_i, // System clock
   input wire logic sys_rst_i, // Async reset, active high
   fcio_link_if.slave link, // Bus side
   input wire logic [ADDR_W-1:0] own_addr_i, // Station address
   input wire logic [ADDR_W-1:0] grp_addr_i, // Group address
   input wire fcio_cfg_t actual_cfg_i, // Real device config
   input wire logic [TMR_W-1:0] wd_limit_i, // Watchdog interval
   input wire logic [DATA_W-1:0] phys_in_i, // Process inputs
   input wire logic [DATA_W-1:0] safe_out_i, // Fail-safe value
   output logic [DATA_W-1:0] phys_out_o, // Process outputs
   output logic in_data_o, // In data transfer phase
   output logic wd_trip_o // Watchdog tripped
);
   typedef struct packed {
      fcio_sphase_t phase;
      logic [ADDR_W-1:0] owner;
      logic sync_on;
      logic frz_on;
      logic [DATA_W-1:0] out_store;
      logic [DATA_W-1:0] out_phys;
      logic [DATA_W-1:0] in_frz;
      logic [TMR_W-1:0] wd_cnt;
      logic wd_trip;
      logic rsp_valid;
      logic [DATA_W-1:0] rsp_data;
      logic rsp_ok;
      logic [ADDR_W-1:0] rsp_src;
      logic [DATA_W-1:0] in_s1;
      logic [DATA_W-1:0] in_s2;
      logic in_data;
   } st_t;
   st_t st_r, st_nxt;

   // Inputs come from the field, so they are synchronised first
   always_comb begin
      logic to_me;
      logic multi_hit;
      logic owned;
      logic [DATA_W-1:0] in_live;
      st_nxt = st_r;
      st_nxt.in_s1 = phys_in_i;
      st_nxt.in_s2 = st_r.in_s1;
      st_nxt.rsp_valid = 1'b0;
      to_me = link.m_valid && link.m_dst == own_addr_i;
      multi_hit = link.m_valid && link.m_kind == FK_CONTROL &&
         (link.m_dst == own_addr_i || link.m_dst == grp_addr_i ||
          link.m_dst == ADDR_ALL);
      owned = link.m_src == st_r.owner;
      in_live = st_r.frz_on ? st_r.in_frz : st_r.in_s2;
      // Watchdog counts only while in data transfer
      if (st_r.phase == SP_DATA && st_r.wd_cnt < wd_limit_i) begin
         st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
      end
      if (st_r.phase == SP_DATA && st_r.wd_cnt >= wd_limit_i) begin
         st_nxt.wd_trip = 1'b1;
         st_nxt.out_phys = safe_out_i;
      end
      if (to_me && link.m_kind == FK_PARAM) begin
         st_nxt.phase = SP_WAIT_CFG;
         st_nxt.owner = link.m_src;
         st_nxt.sync_on = 1'b0;
         st_nxt.frz_on = 1'b0;
         st_nxt.rsp_valid = 1'b1;
         st_nxt.rsp_ok = 1'b1;
      end else if (to_me && link.m_kind == FK_CONFIG && owned &&
            st_r.phase == SP_WAIT_CFG) begin
         st_nxt.rsp_valid = 1'b1;
         st_nxt.rsp_ok = link.m_cfg == actual_cfg_i;
         // Mismatch drops back to wait for fresh parameters
         st_nxt.phase = (link.m_cfg == actual_cfg_i) ? SP_DATA
            : SP_WAIT_PRM;
         st_nxt.wd_cnt = TMR_W'(ZERO_CNT);
         st_nxt.wd_trip = 1'b0;
      end else if (to_me && link.m_kind == FK_DATA) begin
         st_nxt.rsp_valid = 1'b1;
         st_nxt.rsp_data = in_live;
         // Non-owners only read the image; phase gate blocks early data
         st_nxt.rsp_ok = owned && st_r.phase == SP_DATA;
         if (owned && st_r.phase == SP_DATA) begin
            st_nxt.wd_cnt = TMR_W'(ZERO_CNT);
            st_nxt.wd_trip = 1'b0;
            st_nxt.out_store = link.m_data;
            if (!st_r.sync_on) begin
               st_nxt.out_phys = link.m_data;
            end
         end
      end else if (multi_hit && owned) begin
         unique case (fcio_cmd_t'(link.m_code))
            CC_SYNC: begin
               st_nxt.sync_on = 1'b1;
               if (st_r.sync_on) begin
                  st_nxt.out_phys = st_r.out_store;
               end
            end
            CC_UNSYNC: st_nxt.sync_on = 1'b0;
            CC_FREEZE: begin
               st_nxt.frz_on = 1'b1;
               st_nxt.in_frz = st_r.in_s2;
            end
            CC_UNFREEZE: st_nxt.frz_on = 1'b0;
         endcase
      end
      // Outputs stay safe outside data transfer
      if (st_r.phase != SP_DATA) begin
         st_nxt.out_phys = safe_out_i;
      end
      st_nxt.rsp_src = own_addr_i;
      // Phase flag kept in a flop so the output is registered
      st_nxt.in_data = st_nxt.phase == SP_DATA;
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Acyclic traffic is not carried here, so it cannot steal cycles
   assign link.s_valid = st_r.rsp_valid;
   assign link.s_src = st_r.rsp_src;
   assign link.s_ok = st_r.rsp_ok;
   assign link.s_data = st_r.rsp_data;
   assign link.s_out_img = st_r.out_phys;
   assign phys_out_o = st_r.out_phys;
   assign in_data_o = st_r.in_data;
   assign wd_trip_o = st_r.wd_trip;
endmodule

// ### tb/fcio_link_monitor.sv
`timescale 1ns/10ps
// Watches the shared link between the master and its one slave
module fcio_link_monitor
   import fcio_pkg::*;
#(
   parameter logic [ADDR_W-1:0] SLV_ADDR = 7'h05, // Watched slave
   parameter int STATUS_CYC = 20 // Status period
)
(
   input wire logic clk_sys_i, // System clock
   input wire logic sys_rst_i, // Async reset
   input wire logic m_valid, // Master strobe
   input wire fcio_kind_t m_kind, // Frame kind
   input wire logic [ADDR_W-1:0] m_dst, // Destination
   input wire logic s_valid, // Slave reply
   input wire logic [ADDR_W-1:0] s_src, // Replier
   input wire logic s_ok // Reply accepted
);
   // Loose ceiling: a poll in flight may push a status frame back
   localparam int GAP_MAX = 2 * STATUS_CYC + 8;
   logic poll, stat, prm_r, cfg_r, cfgq_r;
   int gap_r;
   assign poll = m_valid && m_dst == SLV_ADDR && m_kind != FK_STATUS
      && m_kind != FK_CONTROL;
   assign stat = m_valid && m_kind == FK_STATUS;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   // What the slave has been through since reset
   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prm_r <= 1'b0;
         cfg_r <= 1'b0;
         cfgq_r <= 1'b0;
         gap_r <= 0;
      end else begin
         cfgq_r <= poll && m_kind == FK_CONFIG;
         gap_r <= stat ? 0 : gap_r + 1;
         if (poll && m_kind == FK_PARAM) prm_r <= 1'b1;
         if (poll && m_kind == FK_PARAM) cfg_r <= 1'b0;
         else if (cfgq_r && s_valid && s_ok) cfg_r <= 1'b1;
      end
   end
   AST_REPLY: assert property (poll |=> s_valid && s_src == SLV_ADDR)
      else $error("poll not answered");
   AST_REPLY_PULSE: assert property (s_valid |=> !s_valid)
      else $error("reply longer than one cycle");
   AST_POLL_WAIT: assert property (poll |=> !poll)
      else $error("poll sent before reply");
   AST_STAT_NOREPLY: assert property (stat |=> !s_valid)
      else $error("status frame answered");
   AST_STAT_ALL: assert property (stat |-> m_dst == ADDR_ALL)
      else $error("status not multicast");
   AST_STAT_GAP: assert property (stat |=> !stat [*8])
      else $error("status frames too close");
   AST_STAT_MAX: assert property (gap_r < GAP_MAX)
      else $error("status frame overdue");
   AST_CTRL_NOREPLY: assert property (
      m_valid && m_kind == FK_CONTROL |=> !s_valid)
      else $error("control frame answered");
   AST_PARAM_FIRST: assert property (
      poll && m_kind == FK_CONFIG |-> prm_r)
      else $error("config before parameters");
   AST_CFG_ORDER: assert property (poll && m_kind == FK_DATA |-> cfg_r)
      else $error("data before matching config");
   cover property (poll && m_kind == FK_DATA);
   cover property (m_valid && m_kind == FK_CONTROL);
   cover property (cfgq_r && s_valid && !s_ok);
endmodule

// ### tb/tb_fieldbus_cyclic_io_control.sv
`timescale 1ns/10ps
// Master and slave joined on one link; a second slave is driven directly
module tb_fieldbus_cyclic_io_control;
   import fcio_pkg::*;
   localparam logic [ADDR_W-1:0] S_ADDR = 7'h05;
   logic clk_sys_i;
   logic sys_rst_i = 1'b1;
   logic [ADDR_W-1:0] m_addr = 7'h02;
   logic [ADDR_W-1:0] g_addr = 7'h11;
   fcio_mstate_t req_state = MS_STOP;
   logic auto_clear = 1'b0;
   logic cmd_req = 1'b0;
   fcio_cmd_t cmd_code = CC_SYNC;
   logic [ADDR_W-1:0] cmd_dst = 7'h00;
   logic [DATA_W-1:0] out_data = 8'h00;
   logic [DATA_W-1:0] phys_in = 8'h00;
   logic [DATA_W-1:0] safe_out = 8'hA5;
   logic [TMR_W-1:0] limit = 24'h000040;
   fcio_cfg_t plan_cfg = '{8'h3C, 4'h2, 8'h04, 8'h04};
   fcio_cfg_t act_cfg = '{8'h3C, 4'h2, 8'h04, 8'h04};
   fcio_mstate_t state;
   logic [DATA_W-1:0] m_in, phys_out, phys_out2;
   logic ready, tmr_trip, s_in_data, wd_trip;
   int n_errors = 0;
   int num_checks = 0;
   int seed = 32138;
   logic [DATA_W-1:0] exp_q[$];
   fcio_link_if link();
   fcio_link_if link2();
   // Single assigned slave, so the round robin never waits on silence
   fcio_master #(.NSLV(1), .STATUS_CYC(20)) fcio_master_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link.master),
      .own_addr_i(m_addr), .slv_addr_i(S_ADDR), .plan_cfg_i(plan_cfg),
      .req_state_i(req_state), .auto_clear_i(auto_clear),
      .resp_limit_i(limit), .out_data_i(out_data), .safe_out_i(safe_out),
      .cmd_req_i(cmd_req), .cmd_code_i(cmd_code), .cmd_dst_i(cmd_dst),
      .state_o(state), .in_data_o(m_in), .slv_ready_o(ready),
      .tmr_trip_o(tmr_trip));
   fcio_slave fcio_slave_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link.slave),
      .own_addr_i(S_ADDR), .grp_addr_i(g_addr), .actual_cfg_i(act_cfg),
      .wd_limit_i(limit), .phys_in_i(phys_in), .safe_out_i(safe_out),
      .phys_out_o(phys_out), .in_data_o(s_in_data), .wd_trip_o(wd_trip));
   fcio_slave fcio_slave_inst_b (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link(link2.slave),
      .own_addr_i(S_ADDR), .grp_addr_i(g_addr), .actual_cfg_i(act_cfg),
      .wd_limit_i(limit), .phys_in_i(phys_in), .safe_out_i(safe_out),
      .phys_out_o(phys_out2), .in_data_o(), .wd_trip_o());
   fcio_link_monitor #(.SLV_ADDR(S_ADDR), .STATUS_CYC(20))
      fcio_link_monitor_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .m_valid(link.m_valid), .m_kind(link.m_kind), .m_dst(link.m_dst),
      .s_valid(link.s_valid), .s_src(link.s_src), .s_ok(link.s_ok));
   // 250 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Bounded waits for the slave outputs or the master input copy
   task automatic wait_out(input logic [DATA_W-1:0] v);
      for (int i = 0; i < 300 && phys_out !== v; i++) @(posedge clk_sys_i);
      check(phys_out, v);
   endtask
   task automatic wait_in(input logic [DATA_W-1:0] v);
      for (int i = 0; i < 300 && m_in !== v; i++) @(posedge clk_sys_i);
      check(m_in, v);
   endtask
   // Random byte onto the master outputs or the slave process inputs
   task automatic drive(output logic [DATA_W-1:0] v, input bit is_in);
      v = 8'($random(seed));
      @(posedge clk_sys_i);
      if (is_in) phys_in <= v;
      else out_data <= v;
   endtask
   task automatic command(input fcio_cmd_t c, input logic [ADDR_W-1:0] d);
      @(posedge clk_sys_i);
      cmd_req <= 1'b1;
      cmd_code <= c;
      cmd_dst <= d;
      @(posedge clk_sys_i);
      cmd_req <= 1'b0;
      repeat (30) @(posedge clk_sys_i);
   endtask
   // Frame on the second link; released lines show the inverse value
   task automatic send(input fcio_kind_t k, input logic [ADDR_W-1:0] src,
      input logic [DATA_W-1:0] d, input logic ok);
      @(posedge clk_sys_i);
      link2.m_valid <= 1'b1;
      link2.m_kind <= k;
      link2.m_src <= src;
      link2.m_data <= d;
      @(posedge clk_sys_i);
      link2.m_valid <= 1'b0;
      link2.m_src <= ~src;
      link2.m_data <= ~d;
      #1;
      check({7'h00, link2.s_valid}, 8'h01);
      check({7'h00, link2.s_ok}, {7'h00, ok});
   endtask
   // Hang guard, far beyond the thousand or so cycles of the sequence
   initial begin
      #100000;
      n_errors++;
      test_done();
   end
   initial begin
      logic [DATA_W-1:0] v, held;
      link2.m_valid = 1'b0;
      link2.m_kind = FK_PARAM;
      link2.m_dst = S_ADDR;
      link2.m_src = 7'h00;
      link2.m_code = 2'h0;
      link2.m_cfg = act_cfg;
      link2.m_data = 8'h00;
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      repeat (60) @(posedge clk_sys_i);
      check({7'h00, ready}, 8'h00);
      check({6'h00, state}, {6'h00, MS_STOP});
      check(phys_out, safe_out);
      req_state <= MS_OPERATE;
      for (int i = 0; i < 300 && ready !== 1'b1; i++) @(posedge clk_sys_i);
      check({7'h00, ready}, 8'h01);
      check({7'h00, s_in_data}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         drive(v, 1'b0);
         wait_out(v);
         drive(v, 1'b1);
         wait_in(v);
      end
      // Sync: outputs stay put while later bytes are stored
      command(CC_SYNC, S_ADDR);
      held = out_data;
      for (int i = 0; i < 3; i++) begin
         drive(v, 1'b0);
         exp_q.push_back(v);
      end
      repeat (40) @(posedge clk_sys_i);
      check(phys_out, held);
      command(CC_SYNC, g_addr);
      held = exp_q[$];
      exp_q.delete();
      wait_out(held);
      drive(v, 1'b0);
      repeat (40) @(posedge clk_sys_i);
      check(phys_out, held);
      command(CC_UNSYNC, ADDR_ALL);
      wait_out(v);
      // Freeze: master keeps seeing the captured inputs
      held = phys_in;
      command(CC_FREEZE, ADDR_ALL);
      drive(v, 1'b1);
      repeat (40) @(posedge clk_sys_i);
      check(m_in, held);
      command(CC_FREEZE, S_ADDR);
      wait_in(v);
      held = v;
      drive(v, 1'b1);
      repeat (40) @(posedge clk_sys_i);
      check(m_in, held);
      command(CC_UNFREEZE, g_addr);
      wait_in(v);
      req_state <= MS_CLEAR;
      wait_out(safe_out);
      drive(v, 1'b1);
      wait_in(v);
      check({6'h00, state}, {6'h00, MS_CLEAR});
      req_state <= MS_OPERATE;
      wait_out(out_data);
      // Master stops polling, status frames only: slave watchdog takes outputs safe by itself
      req_state <= MS_STOP;
      for (int i = 0; i < 300 && wd_trip !== 1'b1; i++) @(posedge clk_sys_i);
      check({7'h00, wd_trip}, 8'h01);
      check(phys_out, safe_out);
      // Planned input length now differs from the device
      plan_cfg.in_len <= 8'h05;
      req_state <= MS_OPERATE;
      repeat (300) @(posedge clk_sys_i);
      check({7'h00, ready}, 8'h00);
      check({7'h00, s_in_data}, 8'h00);
      check(phys_out, safe_out);
      check({7'h00, tmr_trip}, 8'h01);
      check({6'h00, state}, {6'h00, MS_OPERATE});
      auto_clear <= 1'b1;
      for (int i = 0; i < 300 && state !== MS_CLEAR; i++) @(posedge clk_sys_i);
      check({6'h00, state}, {6'h00, MS_CLEAR});
      // Second slave: only the station that configured it sets outputs
      v = 8'($random(seed));
      send(FK_PARAM, 7'h09, 8'h00, 1'b1);
      send(FK_CONFIG, 7'h09, 8'h00, 1'b1);
      send(FK_DATA, 7'h03, v, 1'b0);
      check(link2.s_data, phys_in);
      check(phys_out2, safe_out);
      send(FK_DATA, 7'h09, v, 1'b1);
      repeat (2) @(posedge clk_sys_i);
      check(phys_out2, v);
      send(FK_DATA, 7'h03, ~v, 1'b0);
      check(link2.s_out_img, v);
      check(phys_out2, v);
      test_done();
   end
endmodule
